// file: dv/rtp_chk.sv
// rtp_chk: port-level properties of the temperature protection block.
// Assumes a bind onto rtp_top; sees its ports only.
`timescale 1ns/1ns
module rtp_chk (
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// bus
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// protection
	input wire logic        trip_block,
	input wire logic        trip_out,
	input wire logic        alarm_out,
	input wire logic        timeout_out
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////
	// bus answers: writes never stall, reads stall one cycle
	a_resp_okay: assert property (hresp == 1'h0) else $error("hresp not okay");
	a_read_stall: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout)
		else $error("read without wait state");
	a_write_fast: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
		else $error("write stalled");
	a_stall_once: assert property (!hreadyout |=> hreadyout) else $error("long stall");
	a_rdata_hold: assert property (!$rose(hreadyout) |-> $stable(hrdata))
		else $error("hrdata moved outside a read");
	////////////////////////////////////////
	// six cycles cover the pin synchroniser, so block must have won by then
	a_block_trip: assert property (trip_block [*6] |-> !trip_out)
		else $error("trip while blocked");
	a_tmo_alarm: assert property ($rose(timeout_out) |-> alarm_out && $past(alarm_out))
		else $error("timeout without alarm");
	a_tmo_drop: assert property ($fell(alarm_out) |=> !timeout_out)
		else $error("timeout outlived alarm");
endmodule // rtp_chk
bind rtp_top rtp_chk i_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
	.hresp, .hrdata, .trip_block, .trip_out, .alarm_out, .timeout_out);

// file: dv/rtp_scan_model.sv
// rtp_scan_model: remote scanner sending one channel word per toggle.
// Assumes the device takes a word only on a toggle edge of scan_toggle.
`timescale 1ns/1ns
module rtp_scan_model (
	// clock
	input  wire logic   hclk,
	// scanner pins
	output logic        scan_toggle,
	output logic [3:0]  scan_chan,
	output logic [11:0] scan_temp
);
	////////////////////////////////////////
	// idle pins carry junk; nothing is taken without a toggle
	initial begin
		scan_toggle = 1'h0;
		scan_chan   = 4'hF;
		scan_temp   = 12'hA5A;
	end
	// one word: 3 clocks setup, toggle, 4 clocks hold, then junk
	task automatic send(input logic [3:0] ch, input logic [11:0] t);
		@(posedge hclk);
		scan_chan <= ch;
		scan_temp <= t;
		repeat (3) @(posedge hclk);
		scan_toggle <= ~scan_toggle;
		repeat (4) @(posedge hclk);
		scan_chan <= ~ch; // hold ran out, so no stale value stays
		scan_temp <= ~t;
	endtask
endmodule // rtp_scan_model

// file: dv/tb_rtd_temperature_protection.sv
// tb_rtd_temperature_protection: self-checking bench of rtp_top.
// Assumes rtp_top, rtp_scan_model and the bound checker are compiled.
`timescale 1ns/1ns
`define chk(nm, e, s) begin n_compared++; if ((s) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module tb_rtd_temperature_protection;
	logic        hclk, hresetn, hsel, hwrite, trip_block, scan_toggle;
	logic        hreadyout, hresp, trip_out, alarm_out, timeout_out, irq;
	logic [1:0]  htrans;
	logic [3:0]  scan_chan;
	logic [11:0] scan_temp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	int          n_fail = 0;
	int          n_compared = 0;
	typedef struct packed {logic [3:0] ch; logic [11:0] t; logic tr; logic al;} rtp_row_s;
	// trip threshold 0x0C8, alarm 0x064, both release at 0.99 of it
	rtp_row_s    rows [11] = '{
		'{4'h0, 12'h096, 1'h0, 1'h1},
		'{4'h0, 12'h0C8, 1'h1, 1'h1},
		'{4'h0, 12'h0C7, 1'h1, 1'h1},
		'{4'h0, 12'h0C6, 1'h0, 1'h1},
		'{4'h0, 12'h064, 1'h0, 1'h1},
		'{4'h0, 12'h063, 1'h0, 1'h0},
		'{4'hB, 12'h0FA, 1'h1, 1'h1},
		'{4'hB, 12'h000, 1'h0, 1'h0},
		'{4'h6, 12'h07F, 1'h0, 1'h1},
		'{4'h6, 12'h000, 1'h0, 1'h0},
		'{4'hC, 12'h0FA, 1'h0, 1'h0}};
	logic [31:0] vv [5] = '{32'h0102_0003, 32'h0002_0003, 32'h0103_0003, 32'h0102_0003,
		32'h0101_0001};
	logic [31:0] ve [5] = '{32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFD, 32'hFFFF};
	logic [4:0]  vx = 5'h11;

	rtp_top #(.TICK_CYCLES(10)) i_dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.scan_toggle, .scan_chan, .scan_temp, .trip_block,
		.trip_out, .alarm_out, .timeout_out, .irq
	);
	rtp_scan_model i_scan (.hclk, .scan_toggle, .scan_chan, .scan_temp);
	////////////////////////////////////////
	// 250 MHz clock
	initial begin
		hclk = 1'h0;
		forever #2 hclk = ~hclk;
	end
	// a stuck handshake ends here; about fifty times the expected run
	initial begin
		#100000;
		n_fail++;
		test_done;
	end
	////////////////////////////////////////
	// verdict and end of run
	task automatic test_done;
		if (n_fail == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// settle past the edge so outputs are read after they land
	task automatic wt(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask
	// one single transfer; waits for hready, never counts cycles
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'h1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		hsel   <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, {24'h0, a}, d);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, {24'h0, a}, 32'h0);
		`chk("reg", e, rd)
	endtask
	function automatic logic [7:0] ad(input logic [1:0] b, input logic [3:0] i);
		return {b, i, 2'h0};
	endfunction
	////////////////////////////////////////
	// reset, settings, table rows, then the awkward cases
	initial begin
		hresetn    = 1'h0;
		hsel       = 1'h0;
		htrans     = 2'h0;
		haddr      = 32'h0;
		hwrite     = 1'h0;
		hwdata     = 32'h0;
		trip_block = 1'h0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'h1;
		rc(ad(rtp_pkg::BANK_TRIP_THR, 4'h0), 32'hFFF);
		rc(rtp_pkg::OFS_CTRL, 32'h0);
		rc(8'h2C, 32'h0);
		for (int i = 0; i < 16; i++) begin
			wr(ad(rtp_pkg::BANK_TRIP_THR, i[3:0]), 32'h0C8);
			wr(ad(rtp_pkg::BANK_ALM_THR, i[3:0]), 32'h064);
		end
		wr(rtp_pkg::OFS_ALM_DELAY, 32'h2);
		wr(rtp_pkg::OFS_CHAN_EN, 32'hFFFF);
		wr(rtp_pkg::OFS_ALM_EN, 32'hFFFF);
		wr(rtp_pkg::OFS_CTRL, 32'h1);
		foreach (rows[i]) begin
			i_scan.send(rows[i].ch, rows[i].t);
			wt(4);
			`chk("trip", rows[i].tr, trip_out)
			`chk("alarm", rows[i].al, alarm_out)
			if (rows[i].ch < 4'hC) rc(ad(rtp_pkg::BANK_TEMP, rows[i].ch), {20'h0, rows[i].t});
		end
		// timeout needs two ticks of unbroken alarm and drops with it
		i_scan.send(4'h0, 12'h096);
		wt(8);
		`chk("tmo", 1'h0, timeout_out)
		wt(30);
		`chk("tmo", 1'h1, timeout_out)
		i_scan.send(4'h0, 12'h000);
		wt(5);
		`chk("tmo", 1'h0, timeout_out)
		// block kills trips but not alarms
		i_scan.send(4'h0, 12'h0FA);
		@(posedge hclk);
		trip_block <= 1'h1;
		wt(6);
		`chk("blk", 2'h1, {trip_out, alarm_out})
		rc(rtp_pkg::OFS_STAT_TRIP, 32'h0);
		@(posedge hclk);
		trip_block <= 1'h0;
		wt(6);
		`chk("blk", 1'h1, trip_out)
		rc(rtp_pkg::OFS_STAT_TRIP, 32'h1001);
		// global and per-channel enables
		wr(rtp_pkg::OFS_CTRL, 32'h0);
		wt(3);
		`chk("en", 2'h0, {trip_out, alarm_out})
		wr(rtp_pkg::OFS_CTRL, 32'h1);
		wr(rtp_pkg::OFS_CHAN_EN, 32'hEFFE);
		wt(3);
		`chk("en", 2'h0, {trip_out, alarm_out})
		// voting on ch0 and ch1, both hot
		i_scan.send(4'h1, 12'h0FA);
		wr(rtp_pkg::OFS_CTRL, 32'h3);
		for (int i = 0; i < 5; i++) begin
			wr(rtp_pkg::OFS_VOTE0, vv[i]);
			wr(rtp_pkg::OFS_CHAN_EN, ve[i]);
			wt(5);
			`chk("vote", vx[i], trip_out)
		end
		wr(rtp_pkg::OFS_CTRL, 32'h1);
		wt(3);
		`chk("sel", 1'h1, trip_out)
		// interrupt raised on a trip rise, masked, cleared
		wr(rtp_pkg::OFS_CTRL, 32'h0);
		wr(rtp_pkg::OFS_IRQ_STAT, 32'h7);
		wr(rtp_pkg::OFS_IRQ_MASK, 32'h1);
		wr(rtp_pkg::OFS_CTRL, 32'h1);
		wt(4);
		`chk("irq", 1'h1, irq)
		wr(rtp_pkg::OFS_IRQ_MASK, 32'h0);
		wt(2);
		`chk("irq", 1'h0, irq)
		wr(rtp_pkg::OFS_IRQ_MASK, 32'h1);
		rc(rtp_pkg::OFS_IRQ_MASK, 32'h1);
		wr(rtp_pkg::OFS_IRQ_STAT, 32'h1);
		wt(2);
		`chk("irq", 1'h0, irq)
		// second reset in mid-run
		@(posedge hclk);
		hresetn <= 1'h0;
		wt(2);
		`chk("rst", 4'h8, {hreadyout, hresp, trip_out, irq})
		@(posedge hclk);
		hresetn <= 1'h1;
		wt(2);
		`chk("rst", 4'h8, {hreadyout, hresp, trip_out, irq})
		rc(rtp_pkg::OFS_CHAN_EN, 32'h0);
		rc(ad(rtp_pkg::BANK_ALM_THR, 4'h5), 32'hFFF);
		test_done;
	end
endmodule // tb_rtd_temperature_protection

// file: hw/rtp_channel.sv
// rtp_channel: trip, alarm and timeout alarm of one channel or group.
// Assumes temp and settings are stable register outputs of the same clock.
`timescale 1ns/1ns
module rtp_channel (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// settings and state
	rtp_eval_if.eval e
);
	typedef struct packed {
		logic                       trip;
		logic                       alarm;
		logic                       timeout;
		logic [rtp_pkg::DLY_W-1:0]  cnt;
	} rtp_chan_s;

	rtp_chan_s s;
	rtp_chan_s next_s;

	////////////////////////////////////////////////////////////////////////////
	// threshold with hysteresis; between release level and threshold state holds
	always_comb begin
		next_s = s;
		if (!e.active) begin
			next_s = '0;
		end else begin
			if (e.temp >= e.trip_thr) begin
				next_s.trip = 1'b1;
			end else if (rtp_pkg::released(e.temp, e.trip_thr)) begin
				next_s.trip = 1'b0;
			end
			if (!e.alm_en) begin
				next_s.alarm = 1'b0;
			end else if (e.temp >= e.alm_thr) begin
				next_s.alarm = 1'b1;
			end else if (rtp_pkg::released(e.temp, e.alm_thr)) begin
				next_s.alarm = 1'b0;
			end
			// counter restarts whenever the alarm condition drops out
			if (!next_s.alarm) begin
				next_s.cnt     = '0;
				next_s.timeout = 1'b0;
			// alarm must have stood one clock first, so zero delay never races it
			end else if (s.alarm && (s.cnt >= e.delay)) begin
				next_s.timeout = 1'b1;
			end else if (e.tick) begin
				next_s.cnt = s.cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign e.trip    = s.trip;
	assign e.alarm   = s.alarm;
	assign e.timeout = s.timeout;
endmodule // rtp_channel

// file: hw/rtp_top.sv
// rtp_top: temperature protection with AHB-Lite registers and the scanner input.
// Assumes a single AHB-Lite master with single word transfers; scanner pins are
// asynchronous and hold channel and temperature stable around each toggle.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module rtp_top #(
	parameter int TICK_CYCLES = rtp_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic                       hclk,
	input  wire logic                       hresetn,
	// ahb-lite slave
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic                            hreadyout,
	output logic                            hresp,
	output logic [31:0]                     hrdata,
	// remote scanner, asynchronous pins
	input  wire logic                       scan_toggle,
	input  wire logic [3:0]                 scan_chan,
	input  wire logic [rtp_pkg::TEMP_W-1:0] scan_temp,
	// trip blocking pin, asynchronous
	input  wire logic                       trip_block,
	// protection outputs
	output logic                            trip_out,
	output logic                            alarm_out,
	output logic                            timeout_out,
	output logic                            irq
);
	localparam int NE = rtp_pkg::NUM_EVAL;
	localparam int NC = rtp_pkg::NUM_CH;
	localparam int TW = rtp_pkg::TEMP_W;

	typedef struct packed {
		// bus
		logic                   rd_pend;
		logic                   wr_pend;
		logic                   addr_ok;
		logic [7:0]             addr;
		logic                   hready;
		logic [31:0]            hrdata;
		// settings
		logic                   prot_en;
		logic                   trip_sel;
		logic [NE-1:0]          chan_en;
		logic [NE-1:0]          alm_en;
		logic [15:0]            delay;
		logic [1:0][31:0]       vote;
		logic [NE-1:0][TW-1:0]  trip_thr;
		logic [NE-1:0][TW-1:0]  alm_thr;
		logic [2:0]             irq_st;
		logic [2:0]             irq_mask;
		// scanner and block synchronisers
		logic                   tog1;
		logic                   tog2;
		logic                   tog3;
		logic [3:0]             ch1;
		logic [3:0]             ch2;
		logic [TW-1:0]          tp1;
		logic [TW-1:0]          tp2;
		logic                   blk1;
		logic                   blk2;
		logic [NC-1:0][TW-1:0]  temp;
		// tick prescaler
		logic [31:0]            pre;
		logic                   tick;
		// outputs
		logic                   trip;
		logic                   alarm;
		logic                   timeout;
		logic                   irq;
	} rtp_top_s;

	rtp_top_s s;
	rtp_top_s next_s;

	logic [NE-1:0]          ev_trip;
	logic [NE-1:0]          ev_alarm;
	logic [NE-1:0]          ev_tmo;
	logic [1:0]             vote_trip;
	logic                   accept;
	logic [NE-1:0]          trip_vis;
	logic [2:0]             event_v;
	logic [31:0]            clr;

	////////////////////////////////////////////////////////////////////////////
	// hottest enabled member of a group; disabled channels are left out
	function automatic logic [TW-1:0] hottest(input logic [NC-1:0][TW-1:0] t,
	                                          input logic [NC-1:0] m);
		logic [TW-1:0] h;
		h = '0;
		for (int i = 0; i < NC; i++) begin
			if (m[i] && t[i] > h) begin
				h = t[i];
			end
		end
		return h;
	endfunction

	// register read decode; unmapped locations read zero
	function automatic logic [31:0] read_reg(input rtp_top_s r, input logic [NE-1:0] tv,
	                                         input logic [NE-1:0] al,
	                                         input logic [NE-1:0] tm,
	                                         input logic [1:0] vt);
		logic [31:0] d;
		logic [3:0]  ix;
		d  = 32'h0000_0000;
		ix = r.addr[5:2];
		if (r.addr[7:6] == rtp_pkg::BANK_TRIP_THR) begin
			d[TW-1:0] = r.trip_thr[ix];
		end else if (r.addr[7:6] == rtp_pkg::BANK_ALM_THR) begin
			d[TW-1:0] = r.alm_thr[ix];
		end else if (r.addr[7:6] == rtp_pkg::BANK_TEMP) begin
			if (ix < 4'(NC)) begin
				d[TW-1:0] = r.temp[ix];
			end
		end else begin
			case (r.addr)
				rtp_pkg::OFS_CTRL: begin
					d[rtp_pkg::CTRL_PROT_EN]  = r.prot_en;
					d[rtp_pkg::CTRL_TRIP_SEL] = r.trip_sel;
				end
				rtp_pkg::OFS_CHAN_EN:   d[NE-1:0] = r.chan_en;
				rtp_pkg::OFS_ALM_EN:    d[NE-1:0] = r.alm_en;
				rtp_pkg::OFS_ALM_DELAY: d[15:0]   = r.delay;
				rtp_pkg::OFS_VOTE0:     d         = r.vote[0];
				rtp_pkg::OFS_VOTE1:     d         = r.vote[1];
				rtp_pkg::OFS_STAT_TRIP: d[NE+1:0] = {vt, tv};
				rtp_pkg::OFS_STAT_ALM:  d[NE-1:0] = al;
				rtp_pkg::OFS_STAT_TMO:  d[NE-1:0] = tm;
				rtp_pkg::OFS_IRQ_STAT:  d[2:0]    = r.irq_st;
				rtp_pkg::OFS_IRQ_MASK:  d[2:0]    = r.irq_mask;
				default:                d         = 32'h0000_0000;
			endcase
		end
		return d;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// evaluators: twelve channels then four groups sharing one module
	rtp_eval_if ev_if[NE]();

	for (genvar i = 0; i < NE; i++) begin : g_eval
		if (i < NC) begin : g_ch
			assign ev_if[i].temp = s.temp[i];
		end else begin : g_grp
			assign ev_if[i].temp = hottest(s.temp,
				rtp_pkg::GRP_MEMBERS[i-NC] & s.chan_en[NC-1:0]);
		end
		assign ev_if[i].trip_thr = s.trip_thr[i];
		assign ev_if[i].alm_thr  = s.alm_thr[i];
		assign ev_if[i].delay    = s.delay;
		assign ev_if[i].active   = s.prot_en & s.chan_en[i];
		assign ev_if[i].alm_en   = s.alm_en[i];
		assign ev_if[i].tick     = s.tick;
		assign ev_trip[i]        = ev_if[i].trip;
		assign ev_alarm[i]       = ev_if[i].alarm;
		assign ev_tmo[i]         = ev_if[i].timeout;

		rtp_channel u_eval (
			.hclk    (hclk),
			.hresetn (hresetn),
			.e       (ev_if[i])
		);
	end

	// voting groups watch raw channel trips, blocking is applied afterwards
	for (genvar v = 0; v < rtp_pkg::NUM_VOTE; v++) begin : g_vote
		rtp_voter u_vote (
			.hclk      (hclk),
			.hresetn   (hresetn),
			.func_en   (s.vote[v][rtp_pkg::VOTE_FUNC_EN]),
			.prot_en   (s.prot_en),
			.chan_en   (s.chan_en[NC-1:0]),
			.select    (s.vote[v][NC-1:0]),
			.vote_cnt  (s.vote[v][rtp_pkg::VOTE_CNT_LSB +: 4]),
			.over      (ev_trip[NC-1:0]),
			.vote_trip (vote_trip[v])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// main next-state logic
	always_comb begin
		next_s = s;
		accept = hsel && htrans[1] && hready;
		clr    = 32'h0000_0000;

		// two-stage synchronisers; the second stage is looked at, and tog3 behind it for the toggle edge
		next_s.tog1 = scan_toggle;
		next_s.tog2 = s.tog1;
		next_s.tog3 = s.tog2;
		next_s.ch1  = scan_chan;
		next_s.ch2  = s.ch1;
		next_s.tp1  = scan_temp;
		next_s.tp2  = s.tp1;
		next_s.blk1 = trip_block;
		next_s.blk2 = s.blk1;

		// scanner word lands on a toggle edge; indices of twelve and above are dropped
		if ((s.tog2 ^ s.tog3) && (s.ch2 < 4'(NC))) begin
			next_s.temp[s.ch2] = s.tp2;
		end

		// millisecond tick for alarm delays
		if (s.pre >= 32'(TICK_CYCLES - 1)) begin
			next_s.pre  = 32'h0000_0000;
			next_s.tick = 1'b1;
		end else begin
			next_s.pre  = s.pre + 32'h0000_0001;
			next_s.tick = 1'b0;
		end

		// bus write completes at the end of its zero-wait data phase
		if (s.wr_pend && s.addr_ok) begin
			if (s.addr[7:6] == rtp_pkg::BANK_TRIP_THR) begin
				next_s.trip_thr[s.addr[5:2]] = hwdata[TW-1:0];
			end else if (s.addr[7:6] == rtp_pkg::BANK_ALM_THR) begin
				next_s.alm_thr[s.addr[5:2]] = hwdata[TW-1:0];
			end else begin
				case (s.addr)
					rtp_pkg::OFS_CTRL: begin
						next_s.prot_en  = hwdata[rtp_pkg::CTRL_PROT_EN];
						next_s.trip_sel = hwdata[rtp_pkg::CTRL_TRIP_SEL];
					end
					rtp_pkg::OFS_CHAN_EN:   next_s.chan_en  = hwdata[NE-1:0];
					rtp_pkg::OFS_ALM_EN:    next_s.alm_en   = hwdata[NE-1:0];
					rtp_pkg::OFS_ALM_DELAY: next_s.delay    = hwdata[15:0];
					rtp_pkg::OFS_VOTE0:     next_s.vote[0]  = hwdata & 32'h010F_0FFF;
					rtp_pkg::OFS_VOTE1:     next_s.vote[1]  = hwdata & 32'h010F_0FFF;
					rtp_pkg::OFS_IRQ_STAT:  clr             = hwdata;
					rtp_pkg::OFS_IRQ_MASK:  next_s.irq_mask = hwdata[2:0];
					default: begin
					end
				endcase
			end
		end
		next_s.wr_pend = 1'b0;

		// reads take one wait state so a preceding write is always visible
		if (s.rd_pend) begin
			next_s.hrdata  = s.addr_ok ? read_reg(s, trip_vis, ev_alarm, ev_tmo, vote_trip)
			                           : 32'h0000_0000;
			next_s.hready  = 1'b1;
			next_s.rd_pend = 1'b0;
		end
		if (accept) begin
			next_s.addr    = haddr[7:0];
			next_s.addr_ok = (haddr[31:8] == 24'h00_0000) && (hsize == 3'h2);
			if (hwrite) begin
				next_s.wr_pend = 1'b1;
			end else begin
				next_s.rd_pend = 1'b1;
				next_s.hready  = 1'b0;
			end
		end

		// final trip: default OR or voting OR, never both, then blocked
		next_s.trip = ((s.trip_sel ? |vote_trip : |ev_trip)
		               && !s.blk2);
		next_s.alarm   = |ev_alarm;
		next_s.timeout = |ev_tmo;

		// sticky events on rising outputs; a new event beats a same-cycle clear
		event_v[rtp_pkg::IRQ_TRIP]    = next_s.trip & ~s.trip;
		event_v[rtp_pkg::IRQ_ALARM]   = next_s.alarm & ~s.alarm;
		event_v[rtp_pkg::IRQ_TIMEOUT] = next_s.timeout & ~s.timeout;
		next_s.irq_st = (s.irq_st & ~clr[2:0]) | event_v;
		next_s.irq    = |(next_s.irq_st & next_s.irq_mask);
	end

	// status view of channel and group trips honours the blocking input as well; vote bits do not
	assign trip_vis = ev_trip & {NE{~s.blk2}};

	////////////////////////////////////////////////////////////////////////////
	// state register; thresholds reset to full scale so nothing trips early
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s          <= '0;
			s.hready   <= 1'b1;
			s.delay    <= rtp_pkg::RST_DELAY;
			s.trip_thr <= {NE{rtp_pkg::RST_THR}};
			s.alm_thr  <= {NE{rtp_pkg::RST_THR}};
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from the state register, except hresp which is tied low
	assign hreadyout   = s.hready;
	assign hresp       = 1'b0;
	assign hrdata      = s.hrdata;
	assign trip_out    = s.trip;
	assign alarm_out   = s.alarm;
	assign timeout_out = s.timeout;
	assign irq         = s.irq;
endmodule // rtp_top

// file: hw/rtp_voter.sv
// rtp_voter: one voting group over the sensor channels.
// Assumes over-threshold flags come from the channel evaluators before trip blocking.
`timescale 1ns/1ns
module rtp_voter (
	// clock and reset
	input  wire logic                       hclk,
	input  wire logic                       hresetn,
	// settings
	input  wire logic                       func_en,
	input  wire logic                       prot_en,
	input  wire logic [rtp_pkg::NUM_CH-1:0] chan_en,
	input  wire logic [rtp_pkg::NUM_CH-1:0] select,
	input  wire logic [3:0]                 vote_cnt,
	// channel state
	input  wire logic [rtp_pkg::NUM_CH-1:0] over,
	// result
	output logic                            vote_trip
);
	typedef struct packed {
		logic trip;
	} rtp_vote_s;

	rtp_vote_s                s;
	rtp_vote_s                next_s;
	logic [rtp_pkg::NUM_CH-1:0] voters;

	////////////////////////////////////////////////////////////////////////////
	// a vote count of zero never trips, so an unset group stays quiet
	always_comb begin
		voters = select & chan_en & {rtp_pkg::NUM_CH{prot_en}};
		next_s.trip = func_en && (vote_cnt != 4'h0) &&
			(rtp_pkg::count_ones(voters & over) >= vote_cnt);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign vote_trip = s.trip;
endmodule // rtp_voter

// file: pkg/rtp_eval_if.sv
// rtp_eval_if: settings in and state out of one temperature evaluator.
// Assumes the owner drives every cfg signal from the same clock as the evaluator.
`timescale 1ns/1ns
interface rtp_eval_if;
	logic [rtp_pkg::TEMP_W-1:0] temp;
	logic [rtp_pkg::TEMP_W-1:0] trip_thr;
	logic [rtp_pkg::TEMP_W-1:0] alm_thr;
	logic [rtp_pkg::DLY_W-1:0]  delay;
	logic                       active;
	logic                       alm_en;
	logic                       tick;
	logic                       trip;
	logic                       alarm;
	logic                       timeout;

	modport cfg  (output temp, trip_thr, alm_thr, delay, active, alm_en, tick,
	              input  trip, alarm, timeout);
	modport eval (input  temp, trip_thr, alm_thr, delay, active, alm_en, tick,
	              output trip, alarm, timeout);
endinterface

// file: pkg/rtp_pkg.sv
// rtp_pkg: constants, register map and shared functions of the temperature protection block.
// Assumes a 250 MHz bus clock and temperatures delivered as unsigned raw codes.
// Notes on behaviour
// - each channel has undelayed trip and delayed alarm
// - trip depends only on one threshold
// - alarm has own threshold and enable bit
// - trip and alarm release at 0.99 threshold
// - global enable and per-channel enables
// - winding, ambient, auxiliary groups with own settings
// - group evaluates its hottest channel
// - voting group needs its function enable
// - voting trips when selected over-threshold count reaches vote
// - voting needs select, channel and global enable
// - voting trips forwarded only when selector chooses
// - collective group ORs alarm, timeout, trip
// - collective timeout ORs sensor and group timeouts
// - final trip is default OR or voting OR
// - trip block suppresses all channel and group trips
package rtp_pkg;

	localparam int TEMP_W   = 12;                      // raw temperature code width
	localparam int NUM_CH   = 12;                      // sensor channels
	localparam int NUM_GRP  = 4;                       // winding 1, winding 2, ambient, auxiliary
	localparam int NUM_EVAL = NUM_CH + NUM_GRP;        // evaluators: channels then groups
	localparam int NUM_VOTE = 2;
	localparam int DLY_W    = 16;                      // alarm delay in ticks

	// one delay tick is one millisecond
	localparam int CLK_MHZ     = 250;
	localparam int TICK_US     = 1000;
	localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

	// release ratio 0.99 as a fraction
	localparam logic [6:0] HYST_NUM = 7'h63;
	localparam logic [6:0] HYST_DEN = 7'h64;

	// channel membership of each group, bit i = channel i
	localparam logic [NUM_GRP-1:0][NUM_CH-1:0] GRP_MEMBERS = {
		12'hF00, 12'h0C0, 12'h038, 12'h007};

	// register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_CHAN_EN   = 8'h04;
	localparam logic [7:0] OFS_ALM_EN    = 8'h08;
	localparam logic [7:0] OFS_ALM_DELAY = 8'h0C;
	localparam logic [7:0] OFS_VOTE0     = 8'h10;
	localparam logic [7:0] OFS_VOTE1     = 8'h14;
	localparam logic [7:0] OFS_STAT_TRIP = 8'h18;
	localparam logic [7:0] OFS_STAT_ALM  = 8'h1C;
	localparam logic [7:0] OFS_STAT_TMO  = 8'h20;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h24;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h28;
	localparam logic [1:0] BANK_TRIP_THR = 2'h1;       // 0x40 + 4*i
	localparam logic [1:0] BANK_ALM_THR  = 2'h2;       // 0x80 + 4*i
	localparam logic [1:0] BANK_TEMP     = 2'h3;       // 0xC0 + 4*i

	// field positions
	localparam int CTRL_PROT_EN  = 0;
	localparam int CTRL_TRIP_SEL = 1;
	localparam int VOTE_CNT_LSB  = 16;
	localparam int VOTE_FUNC_EN  = 24;
	localparam int IRQ_TRIP      = 0;
	localparam int IRQ_ALARM     = 1;
	localparam int IRQ_TIMEOUT   = 2;

	// reset values
	localparam logic [TEMP_W-1:0] RST_THR   = 12'hFFF;
	localparam logic [DLY_W-1:0]  RST_DELAY = 16'h0000;

	// true once temp has fallen to 0.99 of thr or below
	function automatic logic released(input logic [TEMP_W-1:0] temp,
	                                  input logic [TEMP_W-1:0] thr);
		logic [TEMP_W+6:0] lhs;
		logic [TEMP_W+6:0] rhs;
		lhs = temp * HYST_DEN;
		rhs = thr * HYST_NUM;
		return lhs <= rhs;
	endfunction

	// number of set bits among channels
	function automatic logic [3:0] count_ones(input logic [NUM_CH-1:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < NUM_CH; i++) begin
			n = n + {3'h0, v[i]};
		end
		return n;
	endfunction

endpackage
